// ### pkg/rx_align_pkg.sv
package rx_align_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int NUM_CH   = 4;
  localparam int DESER    = 8;
  localparam int HIST_W   = 3 * DESER;
  localparam int CNT_W    = 4;
  localparam int BITC_W   = 3;
  localparam int LEAD_CH  = 0;
  localparam int SYNC_LEN = 2;

  // ----------------------------------------------------------------
  // Counts and reset values
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0]  SLIP_LIMIT_MAX = 4'hB;
  localparam logic [CNT_W-1:0]  SLIP_LIMIT_MIN = 4'h1;
  localparam logic [CNT_W-1:0]  SLIP_DEFAULT   = 4'h8;
  localparam logic [CNT_W-1:0]  CNT_ZERO       = 4'h0;
  localparam logic [CNT_W-1:0]  CNT_ONE        = 4'h1;
  localparam logic [BITC_W-1:0] BITC_ZERO      = 3'h0;
  localparam logic [BITC_W-1:0] BITC_ONE       = 3'h1;
  localparam logic [BITC_W-1:0] BITC_LAST      = 3'h7;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef logic [DESER-1:0]  word_t;
  typedef logic [HIST_W-1:0] hist_t;
  typedef logic [CNT_W-1:0]  cnt_t;

  typedef enum logic [1:0] {
    BUF_RAM = 2'h0,
    BUF_LE  = 2'h1,
    BUF_MUX = 2'h2
  } sync_buf_t;

  typedef enum logic [1:0] {
    SLIP_ARMED = 2'b01,
    SLIP_HELD  = 2'b10
  } slip_state_t;

  typedef struct packed {
    word_t [NUM_CH-1:0]      data;
    logic  [NUM_CH-1:0]      valid;
    logic  [NUM_CH-1:0]      rollover;
    cnt_t  [NUM_CH-1:0]      slip_count;
  } rx_out_t;

  typedef struct packed {
    logic [NUM_CH-1:0]       pulse;
    logic                    clear;
  } slip_ctl_t;

  typedef struct packed {
    logic [BITC_W-1:0]       bitcnt;
    word_t                   shift;
    word_t                   slot0;
    word_t                   slot1;
    logic                    tgl;
  } cap_state_t;

  typedef struct packed {
    slip_state_t             st;
    logic                    tgl_seen;
    hist_t                   hist;
    logic                    slip_q;
    cnt_t                    cnt;
    logic                    roll;
    word_t                   data;
    logic                    valid;
  } lane_state_t;

endpackage : rx_align_pkg

// ### verilog/cdc_sync.sv
`timescale 1ns/10ps
`default_nettype none

module cdc_sync #(
  parameter int W = 1
) (
  // Clock and reset of the receiving domain
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Level from another domain
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  import rx_align_pkg::*;

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_state_t;

  sync_state_t s_q;
  sync_state_t s_d;

  // First stage feeds only the second stage
  always_comb begin
    s_d        = s_q;
    s_d.meta   = d;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign q = s_q.stable;

endmodule : cdc_sync
`default_nettype wire

// ### verilog/serial_lane_capture.sv
`timescale 1ns/10ps
`default_nettype none

module serial_lane_capture #(
  parameter bit RISE_EDGE = 1'b1,
  parameter bit PING_PONG = 1'b1
) (
  // Link clock domain
  input  wire logic               lclk,
  input  wire logic               lrst_n,
  // Serial data
  input  wire logic               serial_in,
  // Word slots toward the fabric domain
  output rx_align_pkg::word_t     slot0,
  output rx_align_pkg::word_t     slot1,
  output logic                    word_tgl
);
  import rx_align_pkg::*;

  logic       bit_q;
  cap_state_t s_q;
  cap_state_t s_d;
  word_t      word_done;

  // ----------------------------------------------------------------
  // Capture edge
  // ----------------------------------------------------------------
  generate
    if (RISE_EDGE) begin : g_rise
      always_ff @(posedge lclk or negedge lrst_n) begin
        if (!lrst_n) begin
          bit_q <= 1'b0;
        end else begin
          bit_q <= serial_in;
        end
      end
    end else begin : g_fall
      // Half a link period later than the rising form
      always_ff @(negedge lclk or negedge lrst_n) begin
        if (!lrst_n) begin
          bit_q <= 1'b0;
        end else begin
          bit_q <= serial_in;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Deserializer
  // ----------------------------------------------------------------
  assign word_done = {s_q.shift[DESER-2:0], bit_q};

  always_comb begin
    s_d       = s_q;
    s_d.shift = word_done;
    s_d.bitcnt = s_q.bitcnt + BITC_ONE;
    if (s_q.bitcnt == BITC_LAST) begin
      s_d.bitcnt = BITC_ZERO;
      // Ping-pong keeps the slot being read stable while the other fills
      if (PING_PONG && !s_q.tgl) begin
        s_d.slot1 = word_done;
      end else begin
        s_d.slot0 = word_done;
      end
      s_d.tgl = ~s_q.tgl;
    end
  end

  always_ff @(posedge lclk or negedge lrst_n) begin
    if (!lrst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign slot0    = s_q.slot0;
  assign slot1    = s_q.slot1;
  assign word_tgl = s_q.tgl;

endmodule : serial_lane_capture
`default_nettype wire

// ### verilog/serial_rx_bitslip_align.sv
`timescale 1ns/10ps
`default_nettype none

// Function
// - Rising-edge setting captures serial data on link rising edge, otherwise falling edge.
// - Capture edge selectable only on dedicated hardware without phase alignment.
// - Falling-edge capture samples data half a link cycle later.
// - Optional soft reset asynchronously clears all receiver logic in logic-element form.
// - Each alignment pulse moves the word boundary one bit, adding one bit latency.
// - Dedicated hardware slips each channel independently.
// - Any high or low time above the minimum is accepted.
// - Slipped data appears on the second parallel cycle after the rising edge.
// - Logic-element form may give every channel its own slip input.
// - Logic-element form may add a parallel-clock register on the slip input.
// - Logic-element form clear input returns slip circuitry to initial state.
// - Output stage is block-memory buffer, logic buffer, or multiplexer with register.
// - Buffer forms keep word alignment; multiplexer form does not guarantee it.
// - Alignment clear input zeroes the slip counter.
// - Rollover output flags the slip counter at its rollover point.
// - Slip count wrapping point is configurable from one to eleven.
module serial_rx_bitslip_align #(
  parameter bit                      IMPL_LE        = 1'b0,
  parameter bit                      DPA_MODE       = 1'b0,
  parameter bit                      RISE_EDGE      = 1'b1,
  parameter bit                      INDEP_SLIP     = 1'b1,
  parameter bit                      SLIP_SYNC_REG  = 1'b0,
  parameter bit                      USE_SOFT_RESET = 1'b0,
  parameter bit                      USE_SLIP_CLEAR = 1'b1,
  parameter rx_align_pkg::cnt_t      SLIP_ROLLOVER  = rx_align_pkg::SLIP_DEFAULT,
  parameter rx_align_pkg::sync_buf_t SYNC_BUF       = rx_align_pkg::BUF_RAM
) (
  // Parallel fabric clock and reset
  input  wire logic                          clk,
  input  wire logic                          resetn,
  // Fast serial link clock
  input  wire logic                          lclk,
  // Serial data, one bit per channel
  input  wire logic [rx_align_pkg::NUM_CH-1:0] serial_in,
  // Optional soft reset of the logic-element form
  input  wire logic                          soft_reset,
  // Slip control from fabric logic
  input  wire rx_align_pkg::slip_ctl_t       slip_ctl,
  // Aligned words and slip status
  output rx_align_pkg::rx_out_t              rx_out
);
  import rx_align_pkg::*;

  // ----------------------------------------------------------------
  // Configuration
  // ----------------------------------------------------------------
  // Edge choice exists only on dedicated hardware without phase alignment
  localparam bit CAP_RISE  = (IMPL_LE || DPA_MODE) ? 1'b1 : RISE_EDGE;
  // Dedicated hardware always slips per channel
  localparam bit PER_CH    = !IMPL_LE || INDEP_SLIP;
  localparam bit EXTRA_REG = IMPL_LE && SLIP_SYNC_REG;
  localparam bit PING_PONG = (SYNC_BUF != BUF_MUX);
  localparam bit SOFT_RST  = IMPL_LE && USE_SOFT_RESET;

  // Out-of-range wrap points fall back to the legal span
  localparam cnt_t ROLL_EFF =
    (SLIP_ROLLOVER > SLIP_LIMIT_MAX) ? SLIP_LIMIT_MAX :
    (SLIP_ROLLOVER < SLIP_LIMIT_MIN) ? SLIP_LIMIT_MIN : SLIP_ROLLOVER;
  localparam cnt_t CNT_LAST = ROLL_EFF - CNT_ONE;

  // ----------------------------------------------------------------
  // Reset network
  // ----------------------------------------------------------------
  logic core_rst_n;
  logic link_rst_n;

  // Soft reset leaves nothing out; there is no clock loop in this block
  assign core_rst_n = resetn && !(SOFT_RST && soft_reset);

  // Release toward the link domain is retimed on the link clock
  cdc_sync #(
    .W     (1)
  ) u_link_rst (
    .clk   (lclk),
    .rst_n (core_rst_n),
    .d     (1'b1),
    .q     (link_rst_n)
  );

  // ----------------------------------------------------------------
  // Per-channel datapath
  // ----------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      word_t       slot0;
      word_t       slot1;
      logic        tgl_link;
      logic        tgl_s;
      word_t       new_word;
      logic        slip_raw;
      logic        slip_eff;
      logic        new_arrival;
      lane_state_t s_q;
      lane_state_t s_d;

      // ------------------------------------------------------------
      // Link side capture and deserializer
      // ------------------------------------------------------------
      serial_lane_capture #(
        .RISE_EDGE (CAP_RISE),
        .PING_PONG (PING_PONG)
      ) u_cap (
        .lclk      (lclk),
        .lrst_n    (link_rst_n),
        .serial_in (serial_in[ch]),
        .slot0     (slot0),
        .slot1     (slot1),
        .word_tgl  (tgl_link)
      );

      // Word event crosses as a toggle
      cdc_sync #(
        .W     (1)
      ) u_tgl (
        .clk   (clk),
        .rst_n (core_rst_n),
        .d     (tgl_link),
        .q     (tgl_s)
      );

      // ------------------------------------------------------------
      // Output synchronization stage
      // ------------------------------------------------------------
      // Buffer forms read the slot finished before the toggle;
      // the multiplexer form reads the single slot that keeps refilling
      // and may catch a word mid-update when timing is marginal.
      always_comb begin
        if (PING_PONG) begin
          new_word = tgl_s ? slot1 : slot0;
        end else begin
          new_word = slot0;
        end
      end

      assign new_arrival = (tgl_s != s_q.tgl_seen);

      // ------------------------------------------------------------
      // Slip input selection
      // ------------------------------------------------------------
      assign slip_raw = PER_CH ? slip_ctl.pulse[ch] : slip_ctl.pulse[LEAD_CH];
      // Optional register costs one cycle of slip latency
      assign slip_eff = EXTRA_REG ? s_q.slip_q : slip_raw;

      // ------------------------------------------------------------
      // Slip state and word boundary
      // ------------------------------------------------------------
      always_comb begin
        s_d        = s_q;
        s_d.slip_q = slip_raw;
        s_d.valid  = new_arrival;

        if (new_arrival) begin
          s_d.tgl_seen = tgl_s;
          s_d.hist     = {s_q.hist[HIST_W-DESER-1:0], new_word};
        end

        unique case (s_q.st)
          SLIP_ARMED: begin
            // Only the rising edge slips; width of the pulse is free
            if (slip_eff) begin
              s_d.st = SLIP_HELD;
              // Older bits shift in: one bit later per slip
              if (s_q.cnt == CNT_LAST) begin
                s_d.cnt = CNT_ZERO;
              end else begin
                s_d.cnt = s_q.cnt + CNT_ONE;
              end
            end
          end
          SLIP_HELD: begin
            // Any low time re-arms the detector
            if (!slip_eff) begin
              s_d.st = SLIP_ARMED;
            end
          end
          default: begin
            s_d.st = SLIP_ARMED;
          end
        endcase

        if (USE_SLIP_CLEAR && slip_ctl.clear) begin
          s_d.cnt    = CNT_ZERO;
          s_d.st     = SLIP_ARMED;
          s_d.slip_q = 1'b0;
        end

        s_d.roll = (s_d.cnt == CNT_LAST);
        // Counter moves on the sampling edge, data one edge later
        s_d.data = s_q.hist[s_q.cnt +: DESER];
      end

      always_ff @(posedge clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
          s_q      <= '0;
          s_q.st   <= SLIP_ARMED;
          s_q.roll <= (CNT_ZERO == CNT_LAST);
        end else begin
          s_q <= s_d;
        end
      end

      // ------------------------------------------------------------
      // Outputs
      // ------------------------------------------------------------
      assign rx_out.data[ch]       = s_q.data;
      assign rx_out.valid[ch]      = s_q.valid;
      assign rx_out.rollover[ch]   = s_q.roll;
      assign rx_out.slip_count[ch] = s_q.cnt;
    end
  endgenerate

endmodule : serial_rx_bitslip_align
`default_nettype wire

// ### bench/rx_align_checker.sv
`timescale 1ns/10ps
`default_nettype none

module rx_align_checker #(
  parameter rx_align_pkg::cnt_t SLIP_ROLLOVER = rx_align_pkg::SLIP_DEFAULT
) (
  // Clock and reset
  input wire logic                    clk,
  input wire logic                    resetn,
  // Watched ports
  input wire rx_align_pkg::slip_ctl_t slip_ctl,
  input wire rx_align_pkg::rx_out_t   rx_out
);
  import rx_align_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_slip0;
    $rose(slip_ctl.pulse[0]) && !slip_ctl.clear |=> rx_out.slip_count[0] ==
      cnt_t'((int'($past(rx_out.slip_count[0])) + 1) % int'(SLIP_ROLLOVER));
  endproperty
  a_slip0: assert property (p_slip0) else $error("slip count ch0 wrong");
  property p_slip3;
    $rose(slip_ctl.pulse[3]) && !slip_ctl.clear |=> rx_out.slip_count[3] ==
      cnt_t'((int'($past(rx_out.slip_count[3])) + 1) % int'(SLIP_ROLLOVER));
  endproperty
  a_slip3: assert property (p_slip3) else $error("slip count ch3 wrong");
  // A clear re-arms the detector, so the edge after it may slip
  property p_hold0;
    !$rose(slip_ctl.pulse[0]) && !slip_ctl.clear && !$past(slip_ctl.clear)
      |=> $stable(rx_out.slip_count[0]);
  endproperty
  a_hold0: assert property (p_hold0) else $error("ch0 slipped without edge");
  property p_clr;
    slip_ctl.clear |=> rx_out.slip_count == '0;
  endproperty
  a_clr: assert property (p_clr) else $error("clear left count");
  property p_roll2;
    rx_out.rollover[2] == (rx_out.slip_count[2] == SLIP_ROLLOVER - CNT_ONE);
  endproperty
  a_roll2: assert property (p_roll2) else $error("rollover ch2 wrong");
  property p_bound1;
    rx_out.slip_count[1] < SLIP_ROLLOVER;
  endproperty
  a_bound1: assert property (p_bound1) else $error("count ch1 past wrap");
  property p_vld0;
    rx_out.valid[0] |=> !rx_out.valid[0];
  endproperty
  a_vld0: assert property (p_vld0) else $error("valid ch0 too long");
  property p_rst;
    @(posedge clk) disable iff (1'b0)
      !resetn |-> rx_out.slip_count == '0 && rx_out.valid == '0 && rx_out.data == '0;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared");

  c_roll: cover property (rx_out.rollover[3]);
  c_clr: cover property (slip_ctl.clear && slip_ctl.pulse[2]);
  c_b2b: cover property ($rose(slip_ctl.pulse[3]) ##[2:3] $rose(slip_ctl.pulse[3]));
endmodule : rx_align_checker

bind serial_rx_bitslip_align rx_align_checker #(.SLIP_ROLLOVER(SLIP_ROLLOVER))
  rx_align_checker_inst (.clk(clk), .resetn(resetn), .slip_ctl(slip_ctl), .rx_out(rx_out));

`default_nettype wire

// ### bench/fabric_aligner.sv
`timescale 1ns/10ps
`default_nettype none

module fabric_aligner (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                resetn,
  // Search control
  input  wire logic                en,
  input  wire rx_align_pkg::word_t chr,
  // Word seen and slip request
  input  wire rx_align_pkg::word_t data,
  output logic                     pulse,
  output logic                     done
);
  import rx_align_pkg::*;
  logic [2:0] wait_q;

  // Waits out the slip latency before judging the word again
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn || !en) begin
      pulse  <= 1'b0;
      done   <= 1'b0;
      wait_q <= 3'h0;
    end else if (wait_q != 3'h0) begin
      pulse  <= 1'b0;
      wait_q <= wait_q - 3'h1;
    end else if (data === chr) begin
      done <= 1'b1;
    end else begin
      pulse  <= 1'b1;
      wait_q <= 3'h4;
    end
  end
endmodule : fabric_aligner

`default_nettype wire

// ### bench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin mismatches++; \
  $display("Error %s expected %h seen %h", nm, e, s); end end

module tb_top;
  import rx_align_pkg::*;
  // Rotation-distinct characters so the search has one answer
  localparam word_t [NUM_CH-1:0] CHR = {8'hB0, 8'h4F, 8'h2C, 8'h17};
  logic              clk = 1'b0;
  logic              lclk = 1'b0;
  logic              resetn = 1'b0;
  logic              srch = 1'b0;
  logic              clr = 1'b0;
  logic [NUM_CH-1:0] serial_in = '0;
  logic [NUM_CH-1:0] tb_pulse = '0;
  logic [NUM_CH-1:0] srch_pulse;
  logic [NUM_CH-1:0] done;
  slip_ctl_t         slip_ctl;
  rx_out_t           rx_out;
  int                seed = 99;
  int                mismatches = 0;
  int                n_tests = 0;
  int                bitn = 0;
  cnt_t              exp_cnt [NUM_CH];
  word_t             prev;

  always #25 clk = ~clk;
  initial #7 forever #24 lclk = ~lclk;
  assign slip_ctl = {srch ? srch_pulse : tb_pulse, clr};

  // Repeating character, MSB first, launched away from the capture edge
  always @(negedge lclk) begin
    for (int c = 0; c < NUM_CH; c++) serial_in[c] <= CHR[c][7 - (bitn % 8)];
    bitn <= bitn + 1;
  end

  serial_rx_bitslip_align serial_rx_bitslip_align_inst (
    .clk(clk), .resetn(resetn), .lclk(lclk), .serial_in(serial_in),
    .soft_reset(1'b0), .slip_ctl(slip_ctl), .rx_out(rx_out));
  fabric_aligner fabric_aligner_inst [NUM_CH-1:0] (
    .clk(clk), .resetn(resetn), .en(srch), .chr(CHR),
    .data(rx_out.data), .pulse(srch_pulse), .done(done));

  function automatic word_t rotr1(input word_t w);
    return {w[0], w[DESER-1:1]};
  endfunction : rotr1
  function automatic cnt_t nxt(input cnt_t k);
    return (k == SLIP_DEFAULT - CNT_ONE) ? CNT_ZERO : k + CNT_ONE;
  endfunction : nxt

  task automatic results();
    if (mismatches == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results

  task automatic chk_cnt();
    for (int c = 0; c < NUM_CH; c++) begin
      `CHK("slip_count", exp_cnt[c], rx_out.slip_count[c])
      `CHK("rollover", exp_cnt[c] == SLIP_DEFAULT - CNT_ONE, rx_out.rollover[c])
    end
  endtask : chk_cnt

  task automatic wait_valid();
    int k;
    k = 0;
    while (rx_out.valid[0] !== 1'b1 && k < 40) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (rx_out.valid[0] !== 1'b1) begin
      mismatches++;
      results();
    end
    @(posedge clk);
    #1;
  endtask : wait_valid

  // Hi is the number of sampled-high edges, lo the extra low edges
  task automatic slip(input int c, input int hi, input int lo);
    prev = rx_out.data[c];
    exp_cnt[c] = nxt(exp_cnt[c]);
    @(posedge clk);
    tb_pulse[c] <= 1'b1;
    for (int j = 1; j <= (hi < 2 ? 2 : hi); j++) begin
      @(posedge clk);
      if (j == hi) tb_pulse[c] <= 1'b0;
      #1;
      if (j == 1) `CHK("data_early", prev, rx_out.data[c])
      if (j == 2) `CHK("data", rotr1(prev), rx_out.data[c])
    end
    repeat (lo) @(posedge clk);
    #1;
    chk_cnt();
  endtask : slip

  initial begin
    int k;
    for (int c = 0; c < NUM_CH; c++) exp_cnt[c] = CNT_ZERO;
    repeat (16) @(posedge clk);
    #1;
    `CHK("reset", rx_out_t'(0), rx_out)
    @(posedge clk);
    resetn <= 1'b1;
    repeat (4) wait_valid();
    repeat (9) slip(3, 1, 0);
    repeat (24) slip($unsigned($random(seed)) % NUM_CH, $unsigned($random(seed)) % 3 + 1,
                     $unsigned($random(seed)) % 3);
    @(posedge clk);
    clr <= 1'b1;
    tb_pulse[2] <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    tb_pulse[2] <= 1'b0;
    @(posedge clk);
    #1;
    for (int c = 0; c < NUM_CH; c++) exp_cnt[c] = CNT_ZERO;
    chk_cnt();
    @(posedge clk);
    srch <= 1'b1;
    k = 0;
    while (done !== '1 && k < 400) begin
      @(posedge clk);
      k++;
    end
    #1;
    // Search that never settles is a failure in itself
    if (done !== '1) begin
      mismatches++;
      results();
    end
    for (int c = 0; c < NUM_CH; c++) `CHK("aligned", CHR[c], rx_out.data[c])
    @(posedge clk);
    resetn <= 1'b0;
    #1;
    `CHK("mid reset", rx_out_t'(0), rx_out)
    results();
  end
endmodule : tb_top

`default_nettype wire
